// ---- src/vcrb_pkg.sv ----
// Shared constants and types of the regulator configuration register bank
package vcrb_pkg;

	// Command codes of the two registers held here
	localparam logic [7:0]  CMD_CONFIG_THREE = 8'h45;
	localparam logic [7:0]  CMD_APP_ID       = 8'h46;

	// Field positions of vr_function_config_three
	localparam int          BIT_FIXED_ZERO   = 15;
	localparam int          BIT_PHASE_SRC    = 12;
	localparam int          BIT_MIN_VOUT_TOP = 11;
	localparam int          BIT_BAL_SS_RUN   = 10;
	localparam int          BIT_BOOST_EN     = 9;
	localparam int          GAIN_CODE_HI     = 8;
	localparam int          GAIN_CODE_LO     = 6;
	localparam int          BIT_TRI_VID_EN   = 5;
	localparam int          BIT_TON_CLAMP    = 4;
	localparam int          BIT_TEMP_SIGN    = 3;
	localparam int          BIT_BOOT_SRC     = 2;
	localparam int          TABLE_SEL_HI     = 1;
	localparam int          TABLE_SEL_LO     = 0;

	// Reset values and writable bits (bit 15 is fixed to zero)
	localparam logic [15:0] CFG3_RESET       = 16'h0000;
	localparam logic [15:0] CFG3_WMASK       = 16'h7fff;
	localparam logic [15:0] APP_ID_RESET     = 16'h0000; // Arbitrary value

	// Phases and analogue figures
	localparam int          NUM_PHASES       = 6;
	localparam logic [3:0]  PHASE_CNT_MAX    = 4'h6;
	localparam int          SENSE_W          = 12;
	localparam logic [12:0] BAL_ERR_MV       = 13'h0032;  // 50 mV
	localparam logic [7:0]  GAIN_MUL_SHIFT   = 8'h05;     // Times 32
	localparam logic [7:0]  GAIN_ADD         = 8'h1f;     // Plus 31
	localparam logic [7:0]  BAL_GAIN_CONST   = 8'h1f;
	localparam logic [10:0] TON_MIN_NS       = 11'h05a;   // 90 ns
	localparam logic [10:0] TON_MAX_NS       = 11'h460;   // 1120 ns
	localparam logic [10:0] MIN_ON_STEP_NS   = 11'h014;

	// Pin-strap boot voltage tables, millivolts
	localparam logic [15:0] BOOT_STEP_T0     = 16'h0064;  // 0.1 V
	localparam logic [15:0] BOOT_MAX_T0      = 16'h05dc;  // 1.5 V
	localparam logic [15:0] BOOT_STEP_T1     = 16'h0032;  // 0.05 V
	localparam logic [15:0] BOOT_MAX_T1      = 16'h060e;  // 1.55 V
	localparam logic [15:0] BOOT_STEP_T2     = 16'h00c8;  // 0.2 V
	localparam logic [15:0] BOOT_MAX_T2      = 16'h0bb8;  // 3.0 V
	localparam logic [15:0] BOOT_STEP_T3     = 16'h0064;  // 0.1 V
	localparam logic [15:0] BOOT_MAX_T3      = 16'h0c1c;  // 3.1 V

	// Final count of the strap watch; the straps are watched for four cycles after reset release
	localparam logic [1:0]  POR_SETTLE       = 2'h3;

	// Register selected by a command code
	typedef enum logic [1:0] {
		VCRB_SEL_NONE = 2'b00,
		VCRB_SEL_CFG3 = 2'b01,
		VCRB_SEL_ID   = 2'b10
	} vcrb_sel_e;

	// Power-on strap capture phases
	typedef enum logic [0:0] {
		VCRB_POR_SAMPLE = 1'b0,
		VCRB_POR_DONE   = 1'b1
	} vcrb_por_e;

endpackage

// ---- src/vcrb_boot_table.sv ----
// Pin-strap boot voltage lookup for the four selectable tables
`timescale 1ns/1ps
module vcrb_boot_table (
	// Selection
	input  wire logic [1:0]  table_sel_i,
	input  wire logic [4:0]  strap_code_i,
	// Result
	output logic      [15:0] boot_mv_o
);
	import vcrb_pkg::*;

	logic [15:0] step;
	logic [15:0] limit;
	logic [15:0] raw;

	// Step and ceiling of the chosen table
	always_comb begin
		case (table_sel_i)
			2'b00: begin
				step  = BOOT_STEP_T0;
				limit = BOOT_MAX_T0;
			end
			2'b01: begin
				step  = BOOT_STEP_T1;
				limit = BOOT_MAX_T1;
			end
			2'b10: begin
				step  = BOOT_STEP_T2;
				limit = BOOT_MAX_T2;
			end
			default: begin
				step  = BOOT_STEP_T3;
				limit = BOOT_MAX_T3;
			end
		endcase
	end

	// Codes beyond the table top saturate rather than wrap
	always_comb begin
		raw       = 16'(step * {11'h000, strap_code_i});
		boot_mv_o = (raw > limit) ? limit : raw;
	end

endmodule

// ---- src/vcrb_top.sv ----
// Configuration register bank and the control decisions it steers
//
// How it works
// - Phase count from config-one bits or pins
// - Sense pins sampled only during power-on
// - Grounded sense pin disables it and above
// - Bit 11 tops the minimum-voltage parameter
// - Bit 10 keeps balance loop running in start
// - Over 50mV error selects large gain
// - Disabled boost means one constant gain
// - Large gain equals code times 32 plus 31
// - Bit 5 enables tri-level VID in PMBus mode
// - High pin picks max, low picks min
// - Middle pin state picks strap boot voltage
// - Clamp on-time to minimum field, top 1120
// - Bit 3 signs the temperature offset
// - Bit 2 picks boot from command or strap
// - After start, command updates target live
// - Bits 1:0 pick the strap voltage table
// - Sixteen-bit read-write application identifier
`timescale 1ns/1ps
module vcrb_top (
	// Clock and reset
	input  wire logic                                       ref_clk_i,
	input  wire logic                                       rst_i,
	// Command port from the PMBus engine
	input  wire logic [7:0]                                 cmd_code_i,
	input  wire logic                                       cmd_wr_i,
	input  wire logic                                       cmd_rd_i,
	input  wire logic [15:0]                                cmd_wdata_i,
	output logic      [15:0]                                cmd_rdata_o,
	output logic                                            cmd_rvalid_o,
	output logic                                            cmd_nack_o,
	// Pins
	input  wire logic [vcrb_pkg::NUM_PHASES-1:0]            phase_sense_pin_grounded_i,
	input  wire logic                                       vid_pwm_pin_high_i,
	input  wire logic                                       vid_pwm_pin_low_i,
	input  wire logic [4:0]                                 temp_boot_strap_pin_i,
	// Values from the rest of the controller
	input  wire logic                                       pmbus_mode_i,
	input  wire logic                                       soft_start_active_i,
	input  wire logic                                       soft_start_done_i,
	input  wire logic [3:0]                                 vr_function_config_one_i,
	input  wire logic [15:0]                                min_output_voltage_low_word_i,
	input  wire logic [7:0]                                 temp_sense_offset_mag_i,
	input  wire logic [15:0]                                vout_command_i,
	input  wire logic [15:0]                                vout_max_i,
	input  wire logic [15:0]                                vout_min_i,
	input  wire logic [vcrb_pkg::NUM_PHASES*vcrb_pkg::SENSE_W-1:0] phase_sense_mv_i,
	input  wire logic [10:0]                                ton_request_ns_i,
	input  wire logic [2:0]                                 min_on_time_code_i,
	// Decisions
	output logic      [3:0]                                 active_phase_count_o,
	output logic      [vcrb_pkg::NUM_PHASES-1:0]            phase_enable_o,
	output logic      [16:0]                                min_output_voltage_param_o,
	output logic                                            balance_hold_o,
	output logic      [7:0]                                 balance_gain_o,
	output logic      [8:0]                                 temp_sense_offset_o,
	output logic      [15:0]                                boot_voltage_mv_o,
	output logic      [15:0]                                target_voltage_mv_o,
	output logic      [10:0]                                ton_ns_o
);
	import vcrb_pkg::*;

	localparam int SYNC_W = NUM_PHASES + 2 + 5;

	logic [15:0]           vr_function_config_three;
	logic [15:0]           application_id_word;
	logic [SYNC_W-1:0]     sync_meta;
	logic [SYNC_W-1:0]     sync_pin;
	logic [SYNC_W-1:0]     sync_in;
	logic [NUM_PHASES-1:0] grounded_s;
	logic                  vid_high_s;
	logic                  vid_low_s;
	logic [4:0]            strap_s;
	vcrb_por_e             por_state;
	logic [1:0]            por_cnt;
	logic [NUM_PHASES-1:0] strap_grounded;
	logic [4:0]            strap_code;
	logic [3:0]            pin_phase_count;
	logic [3:0]            next_phase_count;
	logic [NUM_PHASES-1:0] err_over;
	logic [15:0]           table_mv;
	logic [15:0]           next_boot;
	logic [15:0]           next_target;
	logic [10:0]           min_on_ns;
	logic [10:0]           next_ton;
	logic [7:0]            boost_gain;
	vcrb_sel_e             wr_sel;
	vcrb_sel_e             rd_sel;

	// Command code to register; shared by write and read paths
	function automatic vcrb_sel_e decode_cmd(input logic [7:0] code);
		case (code)
			CMD_CONFIG_THREE: decode_cmd = VCRB_SEL_CFG3;
			CMD_APP_ID:       decode_cmd = VCRB_SEL_ID;
			default:          decode_cmd = VCRB_SEL_NONE;
		endcase
	endfunction

	assign wr_sel = decode_cmd(cmd_code_i);
	assign rd_sel = decode_cmd(cmd_code_i);

	// Register writes; the fixed bit never takes a one
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			vr_function_config_three <= CFG3_RESET;
			application_id_word      <= APP_ID_RESET;
		end else if (cmd_wr_i) begin
			if (wr_sel == VCRB_SEL_CFG3) begin
				vr_function_config_three <= cmd_wdata_i & CFG3_WMASK;
			end
			if (wr_sel == VCRB_SEL_ID) begin
				application_id_word <= cmd_wdata_i;
			end
		end
	end

	// Read answers one cycle after the strobe; unknown codes are refused
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cmd_rdata_o  <= 16'h0000;
			cmd_rvalid_o <= 1'b0;
			cmd_nack_o   <= 1'b0;
		end else begin
			cmd_rvalid_o <= cmd_rd_i && (rd_sel != VCRB_SEL_NONE);
			cmd_nack_o   <= (cmd_rd_i || cmd_wr_i) && (rd_sel == VCRB_SEL_NONE);
			case (rd_sel)
				VCRB_SEL_CFG3: cmd_rdata_o <= cmd_rd_i ? vr_function_config_three
				                                       : cmd_rdata_o;
				VCRB_SEL_ID:   cmd_rdata_o <= cmd_rd_i ? application_id_word
				                                       : cmd_rdata_o;
				default:       cmd_rdata_o <= cmd_rd_i ? 16'h0000 : cmd_rdata_o;
			endcase
		end
	end

	// All pin levels gathered into one bus, lowest phase at bit zero
	assign sync_in = {temp_boot_strap_pin_i, vid_pwm_pin_low_i, vid_pwm_pin_high_i,
		phase_sense_pin_grounded_i};

	// Two-stage synchronisers for every pin level
	genvar gi;
	generate
		for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
			always_ff @(posedge ref_clk_i or posedge rst_i) begin
				if (rst_i) begin
					sync_meta[gi] <= 1'b0;
					sync_pin[gi]  <= 1'b0;
				end else begin
					sync_meta[gi] <= sync_in[gi];
					sync_pin[gi]  <= sync_meta[gi];
				end
			end
		end
	endgenerate

	assign grounded_s = sync_pin[NUM_PHASES-1:0];
	assign vid_high_s = sync_pin[NUM_PHASES];
	assign vid_low_s  = sync_pin[NUM_PHASES+1];
	assign strap_s    = sync_pin[SYNC_W-1:NUM_PHASES+2];

	// Straps are watched only while the power-on window is open
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			por_state      <= VCRB_POR_SAMPLE;
			por_cnt        <= 2'h0;
			strap_grounded <= '0;
			strap_code     <= 5'h00;
		end else begin
			case (por_state)
				VCRB_POR_SAMPLE: begin
					strap_grounded <= grounded_s;
					strap_code     <= strap_s;
					por_cnt        <= por_cnt + 2'h1;
					if (por_cnt == POR_SETTLE) begin
						por_state <= VCRB_POR_DONE;
					end
				end
				VCRB_POR_DONE: begin
					por_state <= VCRB_POR_DONE; // Later pin changes are ignored
				end
				default: begin
					por_state <= VCRB_POR_SAMPLE;
				end
			endcase
		end
	end

	// The first grounded sense pin cuts off that phase and all above it
	always_comb begin
		pin_phase_count = 4'h0;
		for (int i = NUM_PHASES - 1; i >= 0; i--) begin
			if (strap_grounded[i]) begin
				pin_phase_count = 4'(i);
			end
		end
		if (strap_grounded == '0) begin
			pin_phase_count = PHASE_CNT_MAX;
		end
	end

	// Software count is capped at the number of phases the part has
	always_comb begin
		if (vr_function_config_three[BIT_PHASE_SRC]) begin
			next_phase_count = pin_phase_count;
		end else if (vr_function_config_one_i > PHASE_CNT_MAX) begin
			next_phase_count = PHASE_CNT_MAX;
		end else begin
			next_phase_count = vr_function_config_one_i;
		end
	end

	// Phase count and per-phase enables
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			active_phase_count_o <= 4'h0;
			phase_enable_o       <= '0;
		end else begin
			active_phase_count_o <= next_phase_count;
			for (int i = 0; i < NUM_PHASES; i++) begin
				phase_enable_o[i] <= (4'(i) < next_phase_count);
			end
		end
	end

	// Error of each phase against phase one
	generate
		for (gi = 0; gi < NUM_PHASES; gi++) begin : g_err
			logic [12:0] diff;
			assign diff = {1'b0, phase_sense_mv_i[gi*SENSE_W +: SENSE_W]}
				- {1'b0, phase_sense_mv_i[0 +: SENSE_W]};
			assign err_over[gi] = diff[12] ? ((13'h0000 - diff) > BAL_ERR_MV)
				: (diff > BAL_ERR_MV);
		end
	endgenerate

	assign boost_gain = (8'({5'h00, vr_function_config_three[GAIN_CODE_HI:GAIN_CODE_LO]})
		<< GAIN_MUL_SHIFT) + GAIN_ADD;

	// Balance loop hold and gain; the boost only acts past the error limit
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			balance_hold_o <= 1'b0;
			balance_gain_o <= BAL_GAIN_CONST;
		end else begin
			balance_hold_o <= soft_start_active_i
				&& !vr_function_config_three[BIT_BAL_SS_RUN];
			if (vr_function_config_three[BIT_BOOST_EN] && (err_over != '0)) begin
				balance_gain_o <= boost_gain;
			end else begin
				balance_gain_o <= BAL_GAIN_CONST;
			end
		end
	end

	// Parameters that borrow a bit from this register
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			min_output_voltage_param_o <= 17'h00000;
			temp_sense_offset_o        <= 9'h000;
		end else begin
			min_output_voltage_param_o <= {vr_function_config_three[BIT_MIN_VOUT_TOP],
				min_output_voltage_low_word_i};
			temp_sense_offset_o <= {vr_function_config_three[BIT_TEMP_SIGN],
				temp_sense_offset_mag_i};
		end
	end

	vcrb_boot_table u_boot_table (
		.table_sel_i  (vr_function_config_three[TABLE_SEL_HI:TABLE_SEL_LO]),
		.strap_code_i (strap_code),
		.boot_mv_o    (table_mv)
	);

	// Boot voltage source and target selection
	always_comb begin
		next_boot = vr_function_config_three[BIT_BOOT_SRC] ? table_mv : vout_command_i;
		if (pmbus_mode_i && vr_function_config_three[BIT_TRI_VID_EN]) begin
			if (vid_high_s) begin
				next_target = vout_max_i;
			end else if (vid_low_s) begin
				next_target = vout_min_i;
			end else begin
				next_target = table_mv;
			end
		end else if (soft_start_done_i) begin
			next_target = vout_command_i;
		end else begin
			next_target = next_boot;
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			boot_voltage_mv_o   <= 16'h0000;
			target_voltage_mv_o <= 16'h0000;
		end else begin
			boot_voltage_mv_o   <= next_boot;
			target_voltage_mv_o <= next_target;
		end
	end

	// On-time clamp; without it the request passes untouched and the
	// configuring side is trusted to stay inside the safe window
	assign min_on_ns = 11'(({8'h00, min_on_time_code_i} + 11'h001) * MIN_ON_STEP_NS);

	always_comb begin
		next_ton = ton_request_ns_i;
		if (vr_function_config_three[BIT_TON_CLAMP]) begin
			if (ton_request_ns_i < min_on_ns) begin
				next_ton = min_on_ns;
			end else if (ton_request_ns_i > TON_MAX_NS) begin
				next_ton = TON_MAX_NS;
			end
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ton_ns_o <= 11'h000;
		end else begin
			ton_ns_o <= next_ton;
		end
	end

	// Checks
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	chk_readback_word: assert property (
		cmd_wr_i && wr_sel == VCRB_SEL_ID ##1 cmd_rd_i && rd_sel == VCRB_SEL_ID
			&& !cmd_wr_i |=> cmd_rvalid_o && cmd_rdata_o == $past(cmd_wdata_i, 2))
		else $error("Identifier word did not read back");

	chk_fixed_bit_zero: assert property (
		cmd_rvalid_o && $past(rd_sel) == VCRB_SEL_CFG3 |-> !cmd_rdata_o[BIT_FIXED_ZERO])
		else $error("Fixed bit read as one");

	chk_pin_count_frozen: assert property (
		por_state == VCRB_POR_DONE |=> $stable(strap_grounded))
		else $error("Phase pins resampled after power-on");

	chk_phase_source_sel: assert property (
		!vr_function_config_three[BIT_PHASE_SRC] && $stable(vr_function_config_three)
			&& vr_function_config_one_i <= PHASE_CNT_MAX
			|=> active_phase_count_o == $past(vr_function_config_one_i))
		else $error("Phase count not taken from config one");

	chk_phase_cutoff: assert property (
		((phase_enable_o + 6'h01) & phase_enable_o) == 6'h00)
		else $error("Higher phase left on above a cut phase");

	chk_hold_softstart: assert property (
		soft_start_active_i && !vr_function_config_three[BIT_BAL_SS_RUN] |=> balance_hold_o)
		else $error("Balance loop not held in soft start");

	chk_boost_gain: assert property (
		vr_function_config_three[BIT_BOOST_EN] && err_over != '0
			|=> balance_gain_o == 8'({5'h00,
				$past(vr_function_config_three[GAIN_CODE_HI:GAIN_CODE_LO])} * 32 + 31))
		else $error("Large gain not applied");

	chk_const_gain: assert property (
		!vr_function_config_three[BIT_BOOST_EN] |=> balance_gain_o == BAL_GAIN_CONST)
		else $error("Gain varied while boost disabled");

	chk_vid_levels: assert property (
		pmbus_mode_i && vr_function_config_three[BIT_TRI_VID_EN] && vid_high_s
			|=> target_voltage_mv_o == $past(vout_max_i))
		else $error("High VID pin did not select maximum");

	chk_ton_clamp: assert property (
		vr_function_config_three[BIT_TON_CLAMP] |=> ton_ns_o <= TON_MAX_NS
			&& ton_ns_o >= $past(min_on_ns))
		else $error("On-time outside clamp window");

	chk_min_vout_top: assert property (
		##1 min_output_voltage_param_o[16] == $past(vr_function_config_three[BIT_MIN_VOUT_TOP]))
		else $error("Minimum voltage top bit wrong");

	cov_pin_phase_mode: cover property (vr_function_config_three[BIT_PHASE_SRC]
		&& por_state == VCRB_POR_DONE && active_phase_count_o < PHASE_CNT_MAX);
	cov_boost_used: cover property (balance_gain_o != BAL_GAIN_CONST);
	cov_vid_middle: cover property (pmbus_mode_i && vr_function_config_three[BIT_TRI_VID_EN]
		&& !vid_high_s && !vid_low_s);
	cov_unmapped: cover property (cmd_nack_o);

endmodule

// ---- tb/vcrb_pin_model.sv ----
// Far-side model: PWM-VID pin source and board phase-sense straps
`timescale 1ns/1ps
module vcrb_pin_model (
	// Clock
	input  wire logic       ref_clk_i,
	// Requests from the bench
	input  wire logic [1:0] vid_level_i,
	input  wire logic [2:0] used_phases_i,
	// Pins
	output logic            vid_high_o,
	output logic            vid_low_o,
	output logic [5:0]      grounded_o
);
	// Comparators: 1 drives high, 2 drives low, else the pin floats to mid
	always_ff @(posedge ref_clk_i) begin
		vid_high_o <= (vid_level_i == 2'h1);
		vid_low_o  <= (vid_level_i == 2'h2);
	end
	// Board grounds every sense pin above the last used phase
	always_ff @(posedge ref_clk_i) begin
		for (int i = 0; i < 6; i++) begin
			grounded_o[i] <= (i >= int'(used_phases_i));
		end
	end
endmodule

// ---- tb/vr_config_register_bank_bench.sv ----
// Self-checking bench of the regulator configuration register bank
`timescale 1ns/1ps
module vr_config_register_bank_bench;
	import vcrb_pkg::*;
	logic        ref_clk_i, rst_i, wr, rd, rv, nk, vh, vl, pm, ssa, ssd, hold;
	logic [7:0]  code, toff_m, gain;
	logic [15:0] wd, rdat, mlo, vcmd, vmax, vmin, boot, tgt, id;
	logic [5:0]  gnd, pen;
	logic [4:0]  strap;
	logic [3:0]  cfg1, pcnt;
	logic [71:0] sense;
	logic [10:0] treq, ton;
	logic [2:0]  tcode, used;
	logic [1:0]  lvl;
	logic [16:0] mpar;
	logic [8:0]  toff;
	logic [11:0] base;
	logic [16:0] q[$];
	logic [15:0] tbl[4] = '{16'h05dc, 16'h03e8, 16'h0bb8, 16'h07d0}; // Strap code 20
	int          error_cnt = 0;
	int          n_tests = 0;

	vcrb_pin_model u_pins (.ref_clk_i(ref_clk_i), .vid_level_i(lvl), .used_phases_i(used),
		.vid_high_o(vh), .vid_low_o(vl), .grounded_o(gnd));
	vcrb_top u_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .cmd_code_i(code), .cmd_wr_i(wr),
		.cmd_rd_i(rd), .cmd_wdata_i(wd), .cmd_rdata_o(rdat), .cmd_rvalid_o(rv), .cmd_nack_o(nk),
		.phase_sense_pin_grounded_i(gnd), .vid_pwm_pin_high_i(vh), .vid_pwm_pin_low_i(vl),
		.temp_boot_strap_pin_i(strap), .pmbus_mode_i(pm), .soft_start_active_i(ssa),
		.soft_start_done_i(ssd), .vr_function_config_one_i(cfg1),
		.min_output_voltage_low_word_i(mlo), .temp_sense_offset_mag_i(toff_m),
		.vout_command_i(vcmd), .vout_max_i(vmax), .vout_min_i(vmin), .phase_sense_mv_i(sense),
		.ton_request_ns_i(treq), .min_on_time_code_i(tcode), .active_phase_count_o(pcnt),
		.phase_enable_o(pen), .min_output_voltage_param_o(mpar), .balance_hold_o(hold),
		.balance_gain_o(gain), .temp_sense_offset_o(toff), .boot_voltage_mv_o(boot),
		.target_voltage_mv_o(tgt), .ton_ns_o(ton));

	// Clock at 25 MHz
	initial begin
		ref_clk_i = 1'b0;
		forever #20 ref_clk_i = ~ref_clk_i;
	end

	task automatic chk(input logic [16:0] got, input logic [16:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic stop_test();
		if (error_cnt == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Requests start at an edge and drop at the edge that takes them
	task automatic wcmd(input logic [7:0] c, input logic [15:0] d);
		wr <= 1'b1;
		code <= c;
		wd <= d;
		@(posedge ref_clk_i);
		wr <= 1'b0;
	endtask

	task automatic rcmd(input logic [7:0] c, input logic [16:0] e);
		q.push_back(e);
		rd <= 1'b1;
		code <= c;
		@(posedge ref_clk_i);
		rd <= 1'b0;
		// Idle edge so a following read never re-raises the strobe at once
		@(posedge ref_clk_i);
	endtask

	// Pins add two sync stages, so five edges covers every path
	task automatic settle();
		repeat (5) @(posedge ref_clk_i);
	endtask

	// Answer monitor: a nack is compared as a flag alone, since rdata may hold
	always @(posedge ref_clk_i) begin
		if (rv === 1'b1 || nk === 1'b1) begin
			if (q.size() == 0) begin
				error_cnt++;
				$display("ERROR %0t got %h exp %h", $time, {nk, rdat}, 17'h0);
			end else begin
				chk(nk === 1'b1 ? 17'h10000 : {1'b0, rdat}, q.pop_front());
			end
		end
	end

	// Hang guard
	initial begin
		repeat (3000) @(posedge ref_clk_i);
		error_cnt++;
		stop_test();
	end

	initial begin
		void'($urandom(32'hf61b28fe));
		{wr, rd, ssa, ssd, lvl, tcode} = '0;
		{code, wd, sense} = '0;
		rst_i = 1'b1;
		pm = 1'b1;
		strap = 5'h14;
		used = 3'h3;
		cfg1 = 4'h5;
		treq = 11'h1f4;
		mlo = 16'($urandom);
		toff_m = 8'($urandom);
		vcmd = 16'($urandom);
		vmax = 16'($urandom);
		vmin = 16'($urandom);
		id = 16'($urandom);
		repeat (4) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		settle();
		settle();
		// Reset values, unmapped codes, back-to-back readback
		rcmd(CMD_CONFIG_THREE, {1'b0, CFG3_RESET});
		rcmd(CMD_APP_ID, {1'b0, APP_ID_RESET});
		rcmd(8'h47, 17'h10000);
		wcmd(CMD_APP_ID, id);
		rcmd(CMD_APP_ID, {1'b0, id});
		q.push_back(17'h10000);
		wcmd(8'h47, ~id);
		rcmd(CMD_APP_ID, {1'b0, id});
		wcmd(CMD_CONFIG_THREE, 16'hffff);
		rcmd(CMD_CONFIG_THREE, {1'b0, CFG3_WMASK});
		// Phase count source and pin capture
		wcmd(CMD_CONFIG_THREE, 16'h0000);
		settle();
		chk(pcnt, 4'h5);
		wcmd(CMD_CONFIG_THREE, 16'h1808);
		settle();
		chk(pcnt, 4'h3);
		chk(pen, 6'h07);
		chk(mpar, {1'b1, mlo});
		chk(toff, {1'b1, toff_m});
		used <= 3'h6;
		settle();
		chk(pcnt, 4'h3);
		// Balance loop hold in soft start
		ssa <= 1'b1;
		wcmd(CMD_CONFIG_THREE, 16'h0400);
		settle();
		chk(hold, 1'b0);
		wcmd(CMD_CONFIG_THREE, 16'h0000);
		settle();
		chk(hold, 1'b1);
		ssa <= 1'b0;
		// Gain boost: 50 mV stays small, 51 mV boosts for every code
		base = 12'($urandom_range(3000, 0));
		sense <= {base, base, base, 12'(base + 12'h032), base, base};
		wcmd(CMD_CONFIG_THREE, 16'h03c0);
		settle();
		chk(gain, 8'h1f);
		sense[35:24] <= base + 12'h033;
		for (int c = 0; c < 8; c++) begin
			wcmd(CMD_CONFIG_THREE, 16'h0200 | 16'(c << 6));
			settle();
			chk(gain, 17'(c * 32 + 31));
		end
		wcmd(CMD_CONFIG_THREE, 16'h01c0);
		settle();
		chk(gain, 8'h1f);
		// Three-level VID: high, low, then middle
		wcmd(CMD_CONFIG_THREE, 16'h0020);
		for (int l = 1; l < 4; l++) begin
			lvl <= 2'(l % 3);
			settle();
			chk(tgt, l == 1 ? vmax : (l == 2 ? vmin : tbl[0]));
		end
		// Strap tables, boot source and live command updates
		for (int s = 0; s < 4; s++) begin
			wcmd(CMD_CONFIG_THREE, 16'h0004 | 16'(s));
			settle();
			chk(boot, tbl[s]);
			chk(tgt, tbl[s]);
		end
		wcmd(CMD_CONFIG_THREE, 16'h0000);
		settle();
		chk(tgt, vcmd);
		ssd <= 1'b1;
		wcmd(CMD_CONFIG_THREE, 16'h0004);
		settle();
		chk(tgt, vcmd);
		pm <= 1'b0;
		lvl <= 2'h1;
		wcmd(CMD_CONFIG_THREE, 16'h0020);
		settle();
		chk(tgt, vcmd);
		// On-time clamp: below the floor, above the ceiling, then unclamped
		tcode <= 3'h2;
		treq <= 11'h01e;
		wcmd(CMD_CONFIG_THREE, 16'h0010);
		settle();
		chk(ton, 11'h03c);
		treq <= 11'h7d0;
		settle();
		chk(ton, TON_MAX_NS);
		wcmd(CMD_CONFIG_THREE, 16'h0000);
		treq <= 11'($urandom_range(1120, 90));
		settle();
		chk(ton, treq);
		repeat (3) @(posedge ref_clk_i);
		chk(17'(q.size()), 17'h0);
		stop_test();
	end
endmodule
